/* File: hdl/dac_ctrl_pkg.sv */
package dac_ctrl_pkg;
   // ****************
   // control word
   // ****************
   localparam int WORD_BITS = 16;
   localparam int RW_BIT    = 15;
   localparam int IDX_MSB   = 14;
   localparam int IDX_LSB   = 8;
   localparam int READ_EDGE = 8;
   localparam logic [4:0] WORD_BITS_W = 5'h10;
   localparam logic [4:0] READ_EDGE_W = 5'h08;

   // ****************
   // register map
   // ****************
   localparam int REG_COUNT = 5;
   localparam logic [6:0] REG_LEFT_ATTEN  = 7'h10;
   localparam logic [6:0] REG_RIGHT_ATTEN = 7'h11;
   localparam logic [6:0] REG_FORMAT      = 7'h12;
   localparam logic [6:0] REG_OUTPUT      = 7'h13;
   localparam logic [6:0] REG_IFMODE      = 7'h14;
   localparam int SLOT_LEFT   = 0;
   localparam int SLOT_RIGHT  = 1;
   localparam int SLOT_FORMAT = 2;
   localparam int SLOT_OUTPUT = 3;
   localparam int SLOT_IFMODE = 4;
   // slot 0 in the low byte; format default is 24-bit i2s (code 3'h5)
   localparam logic [39:0] REG_RESET_ALL = 40'h00_0050_FFFF;
   // bit 7 of the interface-mode register is reserved and reads zero
   localparam logic [39:0] REG_READ_MASK = 40'h7F_FFFF_FFFF;

   // ****************
   // field positions
   // ****************
   localparam int ATTEN_LOAD_ENABLE_BIT  = 7;
   localparam int FMT_LSB   = 4;
   localparam int DMF_LSB   = 2;
   localparam int DME_BIT   = 1;
   localparam int MUTE_BIT  = 0;
   localparam int REV_BIT   = 7;
   localparam int ATS_LSB   = 5;
   localparam int OPE_BIT   = 4;
   localparam int STEREO_BYPASS_SELECT_BIT  = 2;
   localparam int DSD_BIT   = 5;
   localparam int FILTER_BYPASS_BIT  = 4;
   localparam logic [7:0] ATTEN_FULL_SCALE = 8'hFF;
   localparam logic [7:0] ATTEN_FLOOR      = 8'h0F;

   typedef enum logic [1:0] {
      PORT_IDLE  = 2'b00,
      PORT_SHIFT = 2'b01,
      PORT_DONE  = 2'b10
   } port_state_t;

   typedef enum logic [1:0] {
      MODE_PCM    = 2'b00,
      MODE_BYPASS = 2'b01,
      MODE_STREAM = 2'b10
   } iface_mode_t;

   typedef struct packed {
      logic select_n;
      logic bit_clock;
      logic serial_in;
   } ctrl_pins_t;

   typedef struct packed {
      logic word_clock;
      logic bit_clock;
      logic serial_in;
   } audio_pins_t;

   typedef struct packed {
      logic bit_clock;
      logic left;
      logic right;
   } stream_pins_t;

   typedef struct packed {
      iface_mode_t mode;
      logic [7:0]  left_atten_steps;
      logic [7:0]  right_atten_steps;
      logic        left_mute;
      logic        right_mute;
      logic [2:0]  input_format_select;
      logic [1:0]  deemph_rate_select;
      logic [1:0]  stream_filter_select;
      logic        deemph_enable;
      logic        soft_mute;
      logic        phase_invert;
      logic [1:0]  atten_rate_select;
      logic        converter_enable;
   } dac_cfg_t;
endpackage

/* File: hdl/pin_sync.sv */
`timescale 1ns/10ps
module pin_sync #(
   parameter int               WIDTH     = 1,
   parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
   // clock and reset
   input  wire logic             clock,
   input  wire logic             rst,
   // pins
   input  wire logic [WIDTH-1:0] async_in,
   output logic      [WIDTH-1:0] sync_out
);
   if (WIDTH < 1) begin : g_bad_width
      $error("pin_sync width must be at least one");
   end

   // ****************
   // two-stage capture per pin
   // ****************
   for (genvar i = 0; i < WIDTH; i++) begin : g_bit
      logic meta_q;
      always_ff @(posedge clock) begin
         if (rst) begin
            meta_q      <= RESET_VAL[i];
            sync_out[i] <= RESET_VAL[i];
         end else begin
            meta_q      <= async_in[i];
            sync_out[i] <= meta_q;
         end
      end
   end
endmodule

/* File: hdl/stream_capture.sv */
`timescale 1ns/10ps
module stream_capture
   import dac_ctrl_pkg::*;
(
   // clock and reset
   input  wire logic   clock,
   input  wire logic   rst,
   // mode
   input  wire logic   enable,
   input  wire logic   invert,
   // synchronised stream pins
   input  dac_ctrl_pkg::stream_pins_t pins,
   // captured bits
   output logic        left_q,
   output logic        right_q,
   output logic        valid_q
);
   import dac_ctrl_pkg::*;

   logic clk_prev_q;
   logic rise;

   // ****************
   // rising-edge sampling
   // ****************
   always_ff @(posedge clock) begin
      if (rst) begin
         clk_prev_q <= 1'b0;
      end else begin
         clk_prev_q <= pins.bit_clock;
      end
   end

   assign rise = pins.bit_clock && !clk_prev_q;

   // data and clock share one sync depth, so the edge sees matching data
   always_ff @(posedge clock) begin
      if (rst) begin
         left_q  <= 1'b0;
         right_q <= 1'b0;
         valid_q <= 1'b0;
      end else begin
         valid_q <= enable && rise;
         if (enable && rise) begin
            left_q  <= pins.left ^ invert;
            right_q <= pins.right ^ invert;
         end
      end
   end

   chk_stream_sample: assert property (@(posedge clock) disable iff (rst)
      (enable && rise) |=> valid_q && (left_q == $past(pins.left ^ invert)))
      else $error("stream bit not captured on rising edge");
endmodule

/* File: hdl/dac_control_port.sv */
// Contract
// - every transaction is one 16-bit word
// - bits 14 to 8 give register index
// - low byte carries write or read data
// - read data driven after eighth clock
// - write latched after sixteenth clock
// - port runs from its own bit clock
// - filter bypass redefines audio pins
// - stereo bypass takes left/right stream pins
// - stream bits sampled on rising clock
// - stream mode enables; audio clocks grounded
// - per-channel attenuation, default 0 dB
// - common load enable defaults off
// - three-bit input format, default i2s
// - de-emphasis rate or stream filter select
// - de-emphasis and soft mute, pcm only
// - phase invert in every mode
// - attenuation step rate select
// - converter enable, default enabled
// - attenuation is half dB times (value-255)
`timescale 1ns/10ps
module dac_control_port
   import dac_ctrl_pkg::*;
(
   // clock and reset
   input  wire logic                 clock,
   input  wire logic                 rst,
   // control port pins
   input  dac_ctrl_pkg::ctrl_pins_t   ctrl_pins,
   output logic                      ctrl_serial_out,
   output logic                      ctrl_serial_out_en,
   // audio and stream pins
   input  dac_ctrl_pkg::audio_pins_t  audio_pins,
   input  dac_ctrl_pkg::stream_pins_t stream_pins,
   // pcm interface
   output logic                      pcm_word_clock,
   output logic                      pcm_bit_clock,
   output logic                      pcm_serial_data,
   // external filter interface
   output logic                      ext_filter_word_clock,
   output logic                      ext_filter_bit_clock,
   output logic                      ext_filter_mono_data,
   output logic                      ext_filter_left_data,
   output logic                      ext_filter_right_data,
   // one-bit stream
   output logic                      stream_left,
   output logic                      stream_right,
   output logic                      stream_valid,
   // mode settings for the datapath
   output dac_ctrl_pkg::dac_cfg_t     cfg_q
);
   import dac_ctrl_pkg::*;

   // ****************
   // pin synchronisers
   // ****************
   ctrl_pins_t   ctrl_s;
   audio_pins_t  audio_s;
   stream_pins_t stream_s;

   // select resets high so a reset never looks like a started word
   pin_sync #(
      .WIDTH     (9),
      .RESET_VAL (9'h100)
   ) u_sync (
      .clock    (clock),
      .rst      (rst),
      .async_in ({ctrl_pins, audio_pins, stream_pins}),
      .sync_out ({ctrl_s, audio_s, stream_s})
   );

   // ****************
   // control clock edges
   // ****************
   logic mc_prev_q;
   logic mc_rise;
   logic mc_fall;

   always_ff @(posedge clock) begin
      if (rst) begin
         mc_prev_q <= 1'b0;
      end else begin
         mc_prev_q <= ctrl_s.bit_clock;
      end
   end

   // no system clock edge is trusted from the port side; only sampled pins
   assign mc_rise = ctrl_s.bit_clock && !mc_prev_q;
   assign mc_fall = !ctrl_s.bit_clock && mc_prev_q;

   // ****************
   // word framing
   // ****************
   port_state_t       state_q;
   logic [4:0]        bit_cnt_q;
   logic [14:0]       shift_in_q;
   logic [15:0]       word;
   logic [6:0]        cur_index;
   logic              last_bit;
   logic              read_point;
   logic              wr_fire;

   assign word       = {shift_in_q, ctrl_s.serial_in};
   // at the eighth rise the index still sits in the low bits of the shifter
   assign cur_index  = last_bit ? word[IDX_MSB:IDX_LSB] : word[6:0];
   assign last_bit   = (state_q == PORT_SHIFT) && mc_rise && (bit_cnt_q == WORD_BITS_W - 5'h01);
   assign read_point = (state_q == PORT_SHIFT) && mc_rise && (bit_cnt_q == READ_EDGE_W - 5'h01);
   assign wr_fire    = last_bit && !word[RW_BIT];

   always_ff @(posedge clock) begin
      if (rst) begin
         state_q <= PORT_IDLE;
      end else begin
         case (state_q)
            PORT_IDLE: begin
               if (!ctrl_s.select_n) begin
                  state_q <= PORT_SHIFT;
               end
            end
            PORT_SHIFT: begin
               if (ctrl_s.select_n) begin
                  state_q <= PORT_IDLE;
               end else if (last_bit) begin
                  state_q <= PORT_DONE;
               end
            end
            PORT_DONE: begin
               // further clocks ignored until select goes high
               if (ctrl_s.select_n) begin
                  state_q <= PORT_IDLE;
               end
            end
            default: begin
               state_q <= PORT_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         bit_cnt_q  <= 5'h00;
         shift_in_q <= 15'h0000;
      end else if (state_q != PORT_SHIFT) begin
         bit_cnt_q  <= 5'h00;
         shift_in_q <= 15'h0000;
      end else if (mc_rise) begin
         bit_cnt_q  <= bit_cnt_q + 5'h01;
         shift_in_q <= word[14:0];
      end
   end

   // ****************
   // mode registers
   // ****************
   logic [7:0] mode_reg_q [REG_COUNT];
   logic       idx_hit;
   logic [2:0] idx_slot;
   logic [7:0] read_value;

   assign idx_hit  = (cur_index >= REG_LEFT_ATTEN) && (cur_index <= REG_IFMODE);
   assign idx_slot = 3'(cur_index - REG_LEFT_ATTEN);

   always_comb begin
      read_value = 8'h00;
      if (idx_hit) begin
         read_value = mode_reg_q[idx_slot] & REG_READ_MASK[8*idx_slot +: 8];
      end
   end

   for (genvar r = 0; r < REG_COUNT; r++) begin : g_reg
      always_ff @(posedge clock) begin
         if (rst) begin
            mode_reg_q[r] <= REG_RESET_ALL[8*r +: 8];
         end else if (wr_fire && idx_hit && (idx_slot == 3'(r))) begin
            mode_reg_q[r] <= word[7:0];
         end
      end
   end

   // ****************
   // readback shifter
   // ****************
   logic [7:0] rd_shift_q;
   logic       rd_armed_q;

   always_ff @(posedge clock) begin
      if (rst) begin
         rd_shift_q         <= 8'h00;
         rd_armed_q         <= 1'b0;
         ctrl_serial_out    <= 1'b0;
         ctrl_serial_out_en <= 1'b0;
      end else if (state_q == PORT_IDLE) begin
         rd_armed_q         <= 1'b0;
         ctrl_serial_out    <= 1'b0;
         ctrl_serial_out_en <= 1'b0;
      end else if (read_point) begin
         rd_armed_q <= word[7];
         rd_shift_q <= read_value;
      end else if (mc_fall && rd_armed_q && state_q == PORT_SHIFT) begin
         // host samples on the rising edges that follow each fall
         ctrl_serial_out_en <= 1'b1;
         ctrl_serial_out    <= rd_shift_q[7];
         rd_shift_q         <= {rd_shift_q[6:0], 1'b0};
      end
   end

   // ****************
   // mode decode
   // ****************
   logic [7:0]  fmt_r;
   logic [7:0]  out_r;
   logic [7:0]  ifm_r;
   iface_mode_t mode;
   logic        is_pcm;

   assign fmt_r = mode_reg_q[SLOT_FORMAT];
   assign out_r = mode_reg_q[SLOT_OUTPUT];
   assign ifm_r = mode_reg_q[SLOT_IFMODE];
   // stream mode takes precedence when both bits are set
   assign mode   = ifm_r[DSD_BIT] ? MODE_STREAM
                 : (ifm_r[FILTER_BYPASS_BIT] ? MODE_BYPASS : MODE_PCM);
   assign is_pcm = (mode == MODE_PCM);

   always_ff @(posedge clock) begin
      if (rst) begin
         cfg_q.mode                 <= MODE_PCM;
         cfg_q.input_format_select  <= REG_RESET_ALL[8*SLOT_FORMAT+FMT_LSB +: 3];
         cfg_q.deemph_rate_select   <= 2'h0;
         cfg_q.stream_filter_select <= 2'h0;
         cfg_q.deemph_enable        <= 1'b0;
         cfg_q.soft_mute            <= 1'b0;
         cfg_q.phase_invert         <= 1'b0;
         cfg_q.atten_rate_select    <= 2'h0;
         cfg_q.converter_enable     <= 1'b1;
      end else begin
         cfg_q.mode                 <= mode;
         cfg_q.input_format_select  <= fmt_r[FMT_LSB +: 3];
         cfg_q.deemph_rate_select   <= is_pcm ? fmt_r[DMF_LSB +: 2] : 2'h0;
         cfg_q.stream_filter_select <= (mode == MODE_STREAM) ? fmt_r[DMF_LSB +: 2] : 2'h0;
         cfg_q.deemph_enable        <= is_pcm && fmt_r[DME_BIT];
         cfg_q.soft_mute            <= is_pcm && fmt_r[MUTE_BIT];
         cfg_q.phase_invert         <= out_r[REV_BIT];
         cfg_q.atten_rate_select    <= out_r[ATS_LSB +: 2];
         cfg_q.converter_enable     <= !out_r[OPE_BIT];
      end
   end

   // ****************
   // attenuation
   // ****************
   logic load_en;

   // new levels pass only while the common load enable is set
   assign load_en = fmt_r[ATTEN_LOAD_ENABLE_BIT];

   always_ff @(posedge clock) begin
      if (rst) begin
         cfg_q.left_atten_steps  <= 8'h00;
         cfg_q.right_atten_steps <= 8'h00;
         cfg_q.left_mute         <= 1'b0;
         cfg_q.right_mute        <= 1'b0;
      end else if (load_en) begin
         // steps are half-dB units below full scale
         cfg_q.left_atten_steps  <= ATTEN_FULL_SCALE - mode_reg_q[SLOT_LEFT];
         cfg_q.right_atten_steps <= ATTEN_FULL_SCALE - mode_reg_q[SLOT_RIGHT];
         cfg_q.left_mute         <= mode_reg_q[SLOT_LEFT] < ATTEN_FLOOR;
         cfg_q.right_mute        <= mode_reg_q[SLOT_RIGHT] < ATTEN_FLOOR;
      end
   end

   // ****************
   // audio pin routing
   // ****************
   always_ff @(posedge clock) begin
      if (rst) begin
         pcm_word_clock        <= 1'b0;
         pcm_bit_clock         <= 1'b0;
         pcm_serial_data       <= 1'b0;
         ext_filter_word_clock <= 1'b0;
         ext_filter_bit_clock  <= 1'b0;
         ext_filter_mono_data  <= 1'b0;
         ext_filter_left_data  <= 1'b0;
         ext_filter_right_data <= 1'b0;
      end else begin
         pcm_word_clock        <= is_pcm && audio_s.word_clock;
         pcm_bit_clock         <= is_pcm && audio_s.bit_clock;
         pcm_serial_data       <= is_pcm && audio_s.serial_in;
         ext_filter_word_clock <= (mode == MODE_BYPASS) && audio_s.word_clock;
         ext_filter_bit_clock  <= (mode == MODE_BYPASS) && audio_s.bit_clock;
         ext_filter_mono_data  <= (mode == MODE_BYPASS) && audio_s.serial_in;
         ext_filter_left_data  <= (mode == MODE_BYPASS) && out_r[STEREO_BYPASS_SELECT_BIT]
                                  && stream_s.left;
         ext_filter_right_data <= (mode == MODE_BYPASS) && out_r[STEREO_BYPASS_SELECT_BIT]
                                  && stream_s.right;
      end
   end

   // ****************
   // one-bit stream
   // ****************
   stream_capture u_stream (
      .clock   (clock),
      .rst     (rst),
      .enable  (mode == MODE_STREAM),
      .invert  (out_r[REV_BIT]),
      .pins    (stream_s),
      .left_q  (stream_left),
      .right_q (stream_right),
      .valid_q (stream_valid)
   );

   // ****************
   // checks
   // ****************
   chk_word_length: assert property (@(posedge clock) disable iff (rst)
      bit_cnt_q <= WORD_BITS_W)
      else $error("control word counted past sixteen bits");
   chk_write_latch: assert property (@(posedge clock) disable iff (rst)
      (wr_fire && idx_hit) |=> (mode_reg_q[$past(idx_slot)] == $past(word[7:0])))
      else $error("write data not latched after last bit");
   chk_read_drive: assert property (@(posedge clock) disable iff (rst)
      (mc_fall && rd_armed_q && state_q == PORT_SHIFT)
      |=> ctrl_serial_out_en && (ctrl_serial_out == $past(rd_shift_q[7])))
      else $error("readback bit not driven on falling clock");
   chk_out_idle: assert property (@(posedge clock) disable iff (rst)
      (state_q == PORT_IDLE) |=> !ctrl_serial_out_en)
      else $error("serial out driven while idle");
   chk_no_write_drive: assert property (@(posedge clock) disable iff (rst)
      (read_point && !word[7]) |=> !rd_armed_q ##1 !ctrl_serial_out_en[*2])
      else $error("serial out driven during a write");
   chk_atten_map: assert property (@(posedge clock) disable iff (rst)
      load_en |=> cfg_q.left_atten_steps == ATTEN_FULL_SCALE - $past(mode_reg_q[SLOT_LEFT]))
      else $error("attenuation steps do not follow level");
   chk_atten_hold: assert property (@(posedge clock) disable iff (rst)
      !load_en |=> $stable(cfg_q.right_atten_steps))
      else $error("attenuation changed without load enable");
   chk_bypass_route: assert property (@(posedge clock) disable iff (rst)
      (mode == MODE_BYPASS) |=> (ext_filter_bit_clock == $past(audio_s.bit_clock))
      && !pcm_bit_clock)
      else $error("bypass mode did not reroute audio pins");
   chk_stereo_route: assert property (@(posedge clock) disable iff (rst)
      (mode == MODE_BYPASS && out_r[STEREO_BYPASS_SELECT_BIT])
      |=> ext_filter_right_data == $past(stream_s.right))
      else $error("stereo bypass right data not routed");
   chk_mute_pcm: assert property (@(posedge clock) disable iff (rst)
      (mode != MODE_PCM) |=> !cfg_q.soft_mute && !cfg_q.deemph_enable)
      else $error("soft mute or de-emphasis active outside pcm");
endmodule

/* File: test/ctrl_host_model.sv */
`timescale 1ns/10ps
module ctrl_host_model (
   // system clock, used only to pace the link
   input  wire logic               clock,
   // device side
   input  wire logic               serial_out,
   input  wire logic               serial_out_en,
   output dac_ctrl_pkg::ctrl_pins_t pins
);
   import dac_ctrl_pkg::*;
   // 800 ns link period, eight periods of the device clock
   localparam int HALF = 4;

   initial pins = 3'b100;

   task automatic wait_clk(input int n);
      repeat (n) @(negedge clock);
   endtask

   // ****************
   // one frame
   // ****************
   // nbits below 16 aborts the frame on purpose
   task automatic transfer(input logic [15:0] word, input int nbits,
                           output logic [7:0] rd, output logic [15:0] en_seen);
      logic line;
      rd = '0;
      en_seen = '0;
      pins.select_n = 1'b0;
      wait_clk(HALF);
      for (int i = 15; i > 15 - nbits; i--) begin
         pins.serial_in = word[i];
         wait_clk(HALF);
         pins.bit_clock = 1'b1;
         wait_clk(HALF);
         // released line shows no stale value
         line = serial_out_en ? serial_out : ~pins.serial_in;
         en_seen[i] = serial_out_en;
         if (i < 8) rd[i] = line;
         pins.bit_clock = 1'b0;
      end
      wait_clk(HALF);
      pins.select_n = 1'b1;
      pins.serial_in = ~pins.serial_in;
      wait_clk(2 * HALF);
   endtask
endmodule

/* File: test/dac_control_port_bench.sv */
`timescale 1ns/10ps
module dac_control_port_bench;
   import dac_ctrl_pkg::*;
   logic         clock;
   logic         rst;
   ctrl_pins_t   ctrl_pins;
   audio_pins_t  audio_pins;
   stream_pins_t stream_pins;
   logic         ctrl_serial_out, ctrl_serial_out_en;
   logic         pcm_word_clock, pcm_bit_clock, pcm_serial_data;
   logic         ext_filter_word_clock, ext_filter_bit_clock, ext_filter_mono_data;
   logic         ext_filter_left_data, ext_filter_right_data;
   logic         stream_left, stream_right, stream_valid;
   dac_cfg_t     cfg_q;
   int           miscompares, checks_done, vcnt, v0;
   logic [7:0]   d;
   logic [6:0]   idx;
   logic [7:0]   reset_tab [5] = '{8'hFF, 8'hFF, 8'h50, 8'h00, 8'h00};

   dac_control_port dac_control_port_i (.clock, .rst, .ctrl_pins, .ctrl_serial_out,
      .ctrl_serial_out_en, .audio_pins, .stream_pins, .pcm_word_clock, .pcm_bit_clock,
      .pcm_serial_data, .ext_filter_word_clock, .ext_filter_bit_clock,
      .ext_filter_mono_data, .ext_filter_left_data, .ext_filter_right_data,
      .stream_left, .stream_right, .stream_valid, .cfg_q);

   ctrl_host_model ctrl_host_model_i (.clock, .serial_out(ctrl_serial_out),
      .serial_out_en(ctrl_serial_out_en), .pins(ctrl_pins));

   initial begin
      clock = 1'b0;
      forever #50 clock = ~clock;
   end

   always @(posedge clock) if (stream_valid === 1'b1) vcnt++;

   // ****************
   // helpers
   // ****************
   task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
      checks_done++;
      if (got !== exp) begin
         miscompares++;
         $display("unexpected %s: expected %h seen %h", what, exp, got);
      end
   endtask

   // half-dB steps below full scale for a given level
   function automatic logic [7:0] exp_steps(input logic [7:0] level);
      return 8'hFF - level;
   endfunction

   task automatic wr(input logic [6:0] i, input logic [7:0] v);
      logic [7:0]  rd;
      logic [15:0] en;
      ctrl_host_model_i.transfer({1'b0, i, v}, 16, rd, en);
      chk("write enable", 16'h0000, en);
   endtask

   task automatic rd_reg(input logic [6:0] i, input logic [7:0] exp);
      logic [7:0]  rd;
      logic [15:0] en;
      ctrl_host_model_i.transfer({1'b1, i, 8'h00}, 16, rd, en);
      chk("read enable", 16'h00FF, en);
      chk("read data", {8'h00, exp}, {8'h00, rd});
   endtask

   task automatic settle;
      repeat (6) @(negedge clock);
   endtask

   task automatic test_done;
      $display("checks_done %0d miscompares %0d", checks_done, miscompares);
      if (miscompares == 0 && checks_done > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   initial begin
      repeat (20000) @(posedge clock);
      miscompares++;
      test_done();
   end

   // ****************
   // tests
   // ****************
   initial begin
      logic [7:0]  rd;
      logic [15:0] en;
      rst = 1'b1;
      audio_pins = '0;
      stream_pins = '0;
      void'($urandom(32'hf52e));
      repeat (20) @(negedge clock);
      rst = 1'b0;
      repeat (3) @(negedge clock);
      chk("enable dflt", 16'h0001, {15'h0, cfg_q.converter_enable});
      chk("format dflt", 16'h0005, {13'h0, cfg_q.input_format_select});
      chk("atten dflt", 16'h0000, {cfg_q.left_atten_steps, cfg_q.right_atten_steps});
      for (int i = 0; i < 5; i++) rd_reg(REG_LEFT_ATTEN + 7'(i), reset_tab[i]);
      for (int i = 0; i < 4; i++) begin
         audio_pins = 3'($urandom);
         settle();
         chk("pcm path", {13'h0, audio_pins},
             {13'h0, pcm_word_clock, pcm_bit_clock, pcm_serial_data});
      end
      // attenuation needs the common load bit
      wr(REG_LEFT_ATTEN, 8'h80);
      chk("atten held", 16'h0000, {8'h00, cfg_q.left_atten_steps});
      wr(REG_FORMAT, 8'hDF);
      chk("atten left", {8'h00, exp_steps(8'h80)}, {8'h00, cfg_q.left_atten_steps});
      chk("deemph", 16'h0007, {13'h0, cfg_q.deemph_rate_select,
          cfg_q.deemph_enable});
      chk("soft mute", 16'h0001, {15'h0, cfg_q.soft_mute});
      wr(REG_RIGHT_ATTEN, 8'h05);
      chk("mutes", 16'h0001, {14'h0, cfg_q.left_mute, cfg_q.right_mute});
      wr(7'h15, 8'hAA);
      rd_reg(7'h15, 8'h00);
      ctrl_host_model_i.transfer({1'b0, REG_LEFT_ATTEN, 8'h33}, 10, rd, en);
      rd_reg(REG_LEFT_ATTEN, 8'h80);
      // filter bypass with stereo stream pins
      wr(REG_OUTPUT, 8'hD4);
      chk("rate and ope", 16'h0004, {13'h0, cfg_q.atten_rate_select,
          cfg_q.converter_enable});
      wr(REG_IFMODE, 8'h10);
      chk("bypass mode", {14'h0, MODE_BYPASS}, {14'h0, cfg_q.mode});
      for (int i = 0; i < 4; i++) begin
         audio_pins = 3'($urandom);
         stream_pins = {1'b0, 2'($urandom)};
         settle();
         chk("ext filter", {11'h0, audio_pins, stream_pins[1:0]},
             {11'h0, ext_filter_word_clock, ext_filter_bit_clock, ext_filter_mono_data,
              ext_filter_left_data, ext_filter_right_data});
         chk("pcm gated", 16'h0000, {13'h0, pcm_word_clock, pcm_bit_clock,
             pcm_serial_data});
      end
      // stream bit has priority over bypass; audio clocks grounded
      audio_pins = '0;
      wr(REG_OUTPUT, 8'h80);
      wr(REG_IFMODE, 8'h30);
      chk("stream mode", {14'h0, MODE_STREAM}, {14'h0, cfg_q.mode});
      chk("stream cfg", 16'h001C, {9'h0, cfg_q.deemph_rate_select, cfg_q.stream_filter_select,
          cfg_q.phase_invert, cfg_q.deemph_enable, cfg_q.soft_mute});
      for (int i = 0; i < 4; i++) begin
         d = 8'($urandom);
         stream_pins = {1'b0, d[1:0]};
         settle();
         v0 = vcnt;
         stream_pins.bit_clock = 1'b1;
         repeat (8) @(negedge clock);
         chk("stream pulses", 16'h0001, 16'(vcnt - v0));
         chk("stream bits", {14'h0, ~d[1:0]}, {14'h0, stream_left, stream_right});
         stream_pins.bit_clock = 1'b0;
         settle();
      end
      for (int i = 0; i < 10; i++) begin
         idx = REG_LEFT_ATTEN + 7'($urandom_range(4));
         d = 8'($urandom);
         wr(idx, d);
         rd_reg(idx, (idx == REG_IFMODE) ? (d & 8'h7F) : d);
      end
      test_done();
   end
endmodule
